// ---- common/hsc_pkg.sv ----
package hsc_pkg;

    // Program address used after any reset.
    localparam logic [11:0] RESET_ADDR = 12'h000;

    // Clock source selections of the oscillator option.
    typedef enum logic [1:0]
    {
        HSC_CLK_CERAMIC = 2'h0,
        HSC_CLK_RC      = 2'h1,
        HSC_CLK_EXT     = 2'h2
    } hsc_clk_mode_t;

    // Core run state, one-hot.
    typedef enum logic [1:0]
    {
        HSC_RUN  = 2'h1,
        HSC_HALT = 2'h2
    } hsc_state_t;

    // Requests from the processor core.
    typedef struct packed
    {
        logic        halt_exec;
        logic [11:0] next_pc;
    } hsc_core_req_t;

    // Directions to the processor core.
    typedef struct packed
    {
        logic        restart;
        logic        resume;
        logic [11:0] load_pc;
    } hsc_core_ctl_t;

endpackage

// ---- hw/hsc_halt_standby_control.sv ----
`timescale 1ns/1ps
module hsc_halt_standby_control
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   external_reset_pin_n_i,
    input  wire logic [3:0]             port_a_i,
    input  wire logic                   wake_all_pins_i,
    input  wire hsc_pkg::hsc_clk_mode_t clk_mode_i,
    input  wire logic                   serial_done_i,
    input  wire hsc_pkg::hsc_core_req_t core_req_i,
    output logic                        halted_o,
    output logic                        core_clk_en_o,
    output hsc_pkg::hsc_core_ctl_t      core_ctl_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Wake decode.

    hsc_pkg::hsc_state_t state_q;
    hsc_pkg::hsc_state_t state_d;
    logic                release_high;
    logic                release_low;
    logic                rc_mode;
    logic                pin_wake;
    logic                serial_wake;
    logic                reset_wake;
    logic                resume_hit;
    logic                restart_q;
    logic                resume_q;
    logic [11:0]         load_pc_q;

    // A few things the user of this block must keep in mind:
    // - The inputs are taken as synchronous; a bouncing release pin during the
    //   halt cycle can give a halt that is at once undone, or none at all.
    // - The external clock mode is handled like the ceramic mode, so only the
    //   reset pin can end a halt there.
    // - There is no wake mask for the serial completion; a transfer clocked in
    //   from outside ends the halt even during a backup phase.
    // - The core keeps its registers and RAM because only its clock enable is
    //   dropped; nothing here resets them on a pin or serial wake.

    // The release level is one pin, or all four pins when the option selects them.
    assign release_high = wake_all_pins_i ? (&port_a_i) : port_a_i[3];
    assign release_low  = wake_all_pins_i ? (~&port_a_i) : ~port_a_i[3];
    assign rc_mode      = (clk_mode_i == hsc_pkg::HSC_CLK_RC);
    // Pin and serial wakes need the RC oscillator; the ceramic and external paths have only the reset wake.
    assign pin_wake     = release_low & rc_mode;
    assign serial_wake  = serial_done_i & rc_mode;
    assign reset_wake   = ~external_reset_pin_n_i;
    // A wake that resumes at the next instruction is only meaningful while halted.
    assign resume_hit   = (state_q == hsc_pkg::HSC_HALT) & (pin_wake | serial_wake);

    ////////////////////////////////////////////////////////////////////////////
    // Run/halt sequencing.

    // Serial wakes are only looked at once halted; a low release level or reset
    // pin in the halt cycle itself refuses the halt.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            hsc_pkg::HSC_RUN:
            begin
                if (core_req_i.halt_exec && release_high && external_reset_pin_n_i)
                begin
                    state_d = hsc_pkg::HSC_HALT;
                end
            end
            hsc_pkg::HSC_HALT:
            begin
                if (reset_wake || pin_wake || serial_wake)
                begin
                    state_d = hsc_pkg::HSC_RUN;
                end
            end
            default:
            begin
                state_d = hsc_pkg::HSC_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= hsc_pkg::HSC_RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt flag and core clock gate.

    // Halt flag. It follows the next state, so it changes at the very edge that
    // samples the halt instruction or the wake, with no extra cycle of delay.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            halted_o <= 1'b0;
        end
        else
        begin
            halted_o <= (state_d == hsc_pkg::HSC_HALT);
        end
    end

    // Clock gate to the core. Registers and RAM keep their contents while it
    // is off, because only the enable drops and no reset reaches them.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            core_clk_en_o <= 1'b1;
        end
        else
        begin
            core_clk_en_o <= (state_d != hsc_pkg::HSC_HALT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter direction.

    // Restart request. It stands for as long as the reset pin is low, also
    // while running, and is high during the block reset so the core starts
    // cleanly from address zero.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            restart_q <= 1'b1;
        end
        else
        begin
            restart_q <= reset_wake;
        end
    end

    // Resume pulse. The reset pin wins over any other wake, so a serial
    // completion in the same cycle as a low reset pin still restarts.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            resume_q <= 1'b0;
        end
        else
        begin
            resume_q <= resume_hit & ~reset_wake;
        end
    end

    // Address handed to the core. It holds between wakes so that the core may
    // take it at its leisure once its clock runs again.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            load_pc_q <= hsc_pkg::RESET_ADDR;
        end
        else if (reset_wake)
        begin
            load_pc_q <= hsc_pkg::RESET_ADDR;
        end
        else if (resume_hit)
        begin
            load_pc_q <= core_req_i.next_pc;
        end
    end

    // The control bundle is made of flip-flop outputs only.
    assign core_ctl_o.restart = restart_q;
    assign core_ctl_o.resume  = resume_q;
    assign core_ctl_o.load_pc = load_pc_q;

endmodule

// ---- verification/hsc_core_model.sv ----
`timescale 1ns/1ps
// Core stand-in: a held request gives a halt pulse every other cycle.
module hsc_core_model
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              go_i,
    input  wire logic [11:0]       pc_i,
    output hsc_pkg::hsc_core_req_t req_o
);
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) req_o <= '0;
        else req_o <= {go_i && !req_o.halt_exec, pc_i};
endmodule

// ---- verification/hsc_properties.sv ----
`timescale 1ns/1ps
// Port checks of halt entry and of each wake path.
module hsc_properties
(
    input wire logic clk_i, rst_i, external_reset_pin_n_i, wake_all_pins_i,
    input wire logic serial_done_i, halted_o, core_clk_en_o,
    input wire logic [3:0] port_a_i,
    input wire hsc_pkg::hsc_clk_mode_t clk_mode_i,
    input wire hsc_pkg::hsc_core_req_t core_req_i,
    input wire hsc_pkg::hsc_core_ctl_t core_ctl_o
);
    // One low pin is enough in the wide option.
    wire logic rel = wake_all_pins_i ? &port_a_i : port_a_i[3];
    wire logic hw = halted_o && external_reset_pin_n_i;
    wire logic rc = clk_mode_i == hsc_pkg::HSC_CLK_RC;
    wire logic hx = core_req_i.halt_exec && !halted_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_up; !halted_o && core_clk_en_o; endsequence
    halt_entry_a: assert property (hx && rel && external_reset_pin_n_i |=> halted_o)
        else $error("halt not taken");
    halt_refuse_a: assert property (hx && !rel |=> !halted_o) else $error("bad halt");
    reset_wake_a: assert property (halted_o && !external_reset_pin_n_i |=> s_up ##0
        core_ctl_o.restart && core_ctl_o.load_pc == 12'h000) else $error("reset wake");
    serial_wake_a: assert property (hw && serial_done_i && rc |=> s_up ##0
        core_ctl_o.resume && core_ctl_o.load_pc == $past(core_req_i.next_pc)) else $error("sw");
    pin_wake_a: assert property (hw && !rel && rc |=> s_up ##0 core_ctl_o.resume)
        else $error("pin wake");
    stay_halted_a: assert property (hw && !(rc && (!rel || serial_done_i)) |=> halted_o)
        else $error("early wake");
    clock_stop_a: assert property (halted_o |-> !core_clk_en_o) else $error("clk on");
    resume_pulse_a: assert property (core_ctl_o.resume |=> !core_ctl_o.resume)
        else $error("long resume");
endmodule

// ---- verification/tb_halt_standby_control.sv ----
`timescale 1ns/1ps
module tb_halt_standby_control;
    logic clk_i = 0, rst_i = 1, pn = 1, ap = 0, sd = 0, go = 0, h, ce;
    logic [3:0] pa = 4'hf;
    logic [11:0] pc = 12'h000;
    hsc_pkg::hsc_clk_mode_t md = hsc_pkg::HSC_CLK_RC;
    hsc_pkg::hsc_core_req_t rq;
    hsc_pkg::hsc_core_ctl_t ct;
    int n_errors = 0, checks = 0, cyc = 0, w, k;
    always #5 clk_i = ~clk_i;
    hsc_core_model core (.clk_i, .rst_i, .go_i(go), .pc_i(pc), .req_o(rq));
    hsc_halt_standby_control dut (.clk_i, .rst_i, .external_reset_pin_n_i(pn), .port_a_i(pa),
        .wake_all_pins_i(ap), .clk_mode_i(md), .serial_done_i(sd), .core_req_i(rq),
        .halted_o(h), .core_clk_en_o(ce), .core_ctl_o(ct));
    task automatic chk(input string n, input logic [13:0] e, g);
        checks++;
        if (e !== g) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Outside RC mode only the reset pin wakes.
    function automatic bit wakes(int m, int s);
        return s == 0 || m == 1;
    endfunction
    // A run takes about 300 cycles, so this trips only on a hang.
    always @(posedge clk_i) if (++cyc > 2000) begin n_errors++; close_out; end
    initial
    begin
        k = $urandom(17088);
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 40; i++)
        begin
            // Every eighth halt has release low and must be refused.
            @(posedge clk_i);
            md <= hsc_pkg::hsc_clk_mode_t'(i % 3);
            ap <= i % 5 == 4;
            pa <= {i % 8 != 7, 3'h7};
            pc <= 12'($urandom);
            go <= 1;
            @(posedge clk_i) go <= 0;
            @(posedge clk_i) #1 chk("h", 14'(i % 8 != 7), 14'(h));
            chk("ce", 14'(i % 8 == 7), 14'(ce));
            w = $urandom % 3;
            @(posedge clk_i) {pn, pa[3], sd} <= {w != 0, w != 1, w == 2};
            @(posedge clk_i) #1 chk("h", 14'(i % 8 != 7 && !wakes(i % 3, w)), 14'(h));
            chk("ce", 14'(!(i % 8 != 7 && !wakes(i % 3, w))), 14'(ce));
            if (i % 8 != 7 && wakes(i % 3, w))
                chk("ctl", {w == 0, w != 0, w != 0 ? pc : 12'h000}, ct);
            @(posedge clk_i) {pn, sd} <= 2'h0;
            @(posedge clk_i) pn <= 1;
        end
        close_out;
    end
endmodule
bind hsc_halt_standby_control hsc_properties chk_i (.*);
